//--- verilog/omx_exec.sv
// execute logic for or, copy, pointer-load and file-to-file move
//
// Behaviour
// - or literal into accumulator, set n z
// - or accumulator with file, set n z
// - destination bit 0 accumulator, 1 file
// - access bit 0 access bank, 1 bank select
// - 8-bit address reaches whole selected bank
// - load 12-bit literal into chosen pointer
// - pointer load two words, high then low
// - copy file to destination, set n z
// - two-word move, 12-bit source and destination
// - move accepts accumulator as either operand
// - move never writes pc low or stack top
// - move two cycles, write in last phase
`timescale 1ns/1ps
module omx_exec (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire logic [omx_pkg::WORD_W-1:0] i_instr_word,
   input wire logic [3:0] i_bank_select,
   input wire logic [omx_pkg::DATA_W-1:0] i_mem_rdata,
   output logic o_instr_taken,
   output logic o_unsupported,
   output logic o_mem_rd,
   output logic [omx_pkg::ADDR_W-1:0] o_mem_raddr,
   output logic o_mem_wr,
   output logic [omx_pkg::ADDR_W-1:0] o_mem_waddr,
   output logic [omx_pkg::DATA_W-1:0] o_mem_wdata,
   output logic o_move_dest_refused,
   output logic [omx_pkg::DATA_W-1:0] o_accum,
   output logic o_flag_neg,
   output logic o_flag_zero,
   output logic [omx_pkg::ADDR_W-1:0] o_ptr0,
   output logic [omx_pkg::ADDR_W-1:0] o_ptr1,
   output logic [omx_pkg::ADDR_W-1:0] o_ptr2,
   output omx_pkg::omx_phase_t o_phase
);
   import omx_pkg::*;

   omx_phase_t phase;
   logic cycle_start;
   logic cycle_end;
   omx_state_t state_r;
   logic [WORD_W-1:0] word_r;
   logic word_ok_r;
   logic [DATA_W-1:0] accum_r;
   logic neg_r;
   logic zero_r;
   logic [ADDR_W-1:0] ptr_r [PTR_CNT];
   logic [1:0] ptr_sel_r;
   logic [ADDR_W-1:0] move_src_r;
   logic [DATA_W-1:0] opnd_r;
   logic [DATA_W-1:0] result_r;
   logic rd_r;
   logic [ADDR_W-1:0] raddr_r;
   logic wr_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic refused_r;
   logic unsup_r;

   // decoded fields of the current word: input in q1, latch after
   logic is_or_lit;
   logic is_or_file;
   logic is_copy;
   logic is_ptr;
   logic is_move;
   logic dest_file;
   logic [ADDR_W-1:0] file_addr;
   logic [ADDR_W-1:0] dst_addr;
   logic dst_forbidden;
   logic [DATA_W-1:0] result_nxt;
   logic is_accum_src;
   logic [WORD_W-1:0] cur_word;
   logic cur_ok;

   omx_phase_gen u_phase (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .o_phase(phase),
      .o_cycle_start(cycle_start),
      .o_cycle_end(cycle_end)
   );

   // q1 decode must see the incoming word, the latch is one edge late
   assign cur_word = cycle_start ? i_instr_word : word_r;
   assign cur_ok = cycle_start ? i_instr_valid : word_ok_r;
   assign is_or_lit = cur_word[15:8] == OP_OR_LIT;
   assign is_or_file = cur_word[15:10] == OP_OR_FILE;
   assign is_copy = cur_word[15:10] == OP_COPY_FILE;
   assign is_ptr = cur_word[15:6] == OP_LOAD_PTR;
   assign is_move = cur_word[15:12] == OP_MOVE_SRC;
   assign dest_file = cur_word[DEST_BIT];

   // access bank maps low half to bank 0 and high half to the sfr bank
   always_comb begin
      if (cur_word[ACCESS_BIT]) begin
         file_addr = {i_bank_select, cur_word[7:0]};
      end else if (cur_word[7:0] >= ACCESS_SPLIT) begin
         file_addr = {ACCESS_HI_BANK, cur_word[7:0]};
      end else begin
         file_addr = {4'h0, cur_word[7:0]};
      end
   end

   assign dst_addr = cur_word[11:0];
   assign dst_forbidden = (dst_addr == ADDR_PC_LOW) ||
      (dst_addr == ADDR_TOS_LOW) || (dst_addr == ADDR_TOS_HIGH) ||
      (dst_addr == ADDR_TOS_UPPER);
   // accumulator lives in data space, so it is served locally
   assign is_accum_src = raddr_r == ADDR_ACCUM;

   always_comb begin
      if (is_or_lit) begin
         result_nxt = accum_r | word_r[7:0];
      end else if (is_or_file) begin
         result_nxt = accum_r | opnd_r;
      end else begin
         result_nxt = opnd_r;
      end
   end

   // new word latched at q1; the fetch side holds it stable for the cycle
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         word_r <= 16'h0000;
         word_ok_r <= 1'b0;
      end else if (cycle_start) begin
         word_r <= i_instr_word;
         word_ok_r <= i_instr_valid;
      end
   end

   assign o_instr_taken = cycle_start & i_instr_valid;

   // sequencing of two-word instructions
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= OMX_IDLE;
         ptr_sel_r <= 2'h0;
         move_src_r <= 12'h000;
         unsup_r <= 1'b0;
      end else if (cycle_end) begin
         unsup_r <= 1'b0;
         case (state_r)
            OMX_IDLE: begin
               if (word_ok_r && is_ptr && word_r[5:4] != 2'h3) begin
                  state_r <= OMX_PTR_LOW;
                  ptr_sel_r <= word_r[5:4];
               end else if (word_ok_r && is_move) begin
                  state_r <= OMX_MOVE_DST;
                  move_src_r <= word_r[11:0];
               end else if (word_ok_r && !(is_or_lit || is_or_file ||
                            is_copy)) begin
                  unsup_r <= 1'b1;
               end
            end
            OMX_PTR_LOW: begin
               state_r <= OMX_IDLE;
               // a wrong second word aborts the pair
               unsup_r <= !(word_ok_r && word_r[15:8] == OP_LOAD_PTR_2ND);
            end
            OMX_MOVE_DST: begin
               state_r <= OMX_IDLE;
               unsup_r <= !(word_ok_r && word_r[15:12] == OP_MOVE_DST);
            end
            default: begin
               state_r <= OMX_IDLE;
            end
         endcase
      end
   end

   // q2 read of the operand
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rd_r <= 1'b0;
         raddr_r <= 12'h000;
      end else if (phase == OMX_Q1 && cur_ok && state_r == OMX_IDLE &&
                   (is_or_file || is_copy)) begin
         rd_r <= 1'b1;
         raddr_r <= file_addr;
      end else if (phase == OMX_Q1 && cur_ok && state_r == OMX_IDLE &&
                   is_move) begin
         rd_r <= cur_word[11:0] != ADDR_ACCUM;
         raddr_r <= cur_word[11:0];
      end else begin
         // second move cycle has no dummy read
         rd_r <= 1'b0;
      end
   end

   // operand captured at q2 from memory or accumulator
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         opnd_r <= 8'h00;
      end else if (phase == OMX_Q2 && state_r == OMX_IDLE) begin
         opnd_r <= is_accum_src ? accum_r : i_mem_rdata;
      end
   end

   // q3 processes data
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         result_r <= 8'h00;
      end else if (phase == OMX_Q3 && state_r == OMX_IDLE) begin
         result_r <= result_nxt;
      end
   end

   // q4 write: accumulator, flags, memory
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         accum_r <= ACCUM_RST;
         neg_r <= 1'b0;
         zero_r <= 1'b0;
      end else if (phase == OMX_Q4 && word_ok_r) begin
         if (state_r == OMX_IDLE && (is_or_lit ||
             ((is_or_file || is_copy) && !dest_file))) begin
            accum_r <= result_r;
         end else if (state_r == OMX_MOVE_DST &&
                      word_r[15:12] == OP_MOVE_DST &&
                      dst_addr == ADDR_ACCUM) begin
            accum_r <= opnd_r;
         end
         if (state_r == OMX_IDLE && (is_or_lit || is_or_file ||
             is_copy)) begin
            neg_r <= result_r[NEG_BIT];
            zero_r <= result_r == 8'h00;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_r <= 1'b0;
         waddr_r <= 12'h000;
         wdata_r <= 8'h00;
         refused_r <= 1'b0;
      end else if (phase == OMX_Q3 && word_ok_r && state_r == OMX_IDLE &&
                   (is_or_file || is_copy) && dest_file) begin
         wr_r <= 1'b1;
         waddr_r <= file_addr;
         wdata_r <= result_nxt;
         refused_r <= 1'b0;
      end else if (phase == OMX_Q3 && word_ok_r &&
                   state_r == OMX_MOVE_DST &&
                   word_r[15:12] == OP_MOVE_DST) begin
         // status flags untouched by the move
         wr_r <= !dst_forbidden && dst_addr != ADDR_ACCUM;
         waddr_r <= dst_addr;
         wdata_r <= opnd_r;
         refused_r <= dst_forbidden;
      end else begin
         wr_r <= 1'b0;
         refused_r <= 1'b0;
      end
   end

   // pointer registers, high nibble in first cycle, low byte in second
   for (genvar g = 0; g < PTR_CNT; g++) begin : g_ptr
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            ptr_r[g] <= PTR_RST;
         end else if (phase == OMX_Q4 && word_ok_r) begin
            if (state_r == OMX_IDLE && is_ptr && word_r[5:4] == 2'(g)) begin
               ptr_r[g][11:8] <= word_r[3:0];
            end else if (state_r == OMX_PTR_LOW && ptr_sel_r == 2'(g) &&
                         word_r[15:8] == OP_LOAD_PTR_2ND) begin
               ptr_r[g][7:0] <= word_r[7:0];
            end
         end
      end
   end

   assign o_mem_rd = rd_r;
   assign o_mem_raddr = raddr_r;
   assign o_mem_wr = wr_r;
   assign o_mem_waddr = waddr_r;
   assign o_mem_wdata = wdata_r;
   assign o_move_dest_refused = refused_r;
   assign o_unsupported = unsup_r;
   assign o_accum = accum_r;
   assign o_flag_neg = neg_r;
   assign o_flag_zero = zero_r;
   assign o_ptr0 = ptr_r[0];
   assign o_ptr1 = ptr_r[1];
   assign o_ptr2 = ptr_r[2];
   assign o_phase = phase;
endmodule

//--- verilog/omx_pkg.sv
// constants for the or/move/pointer-load execute block
package omx_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned PTR_CNT = 3;
   // opcode patterns, compared against the top bits of a word
   localparam logic [7:0] OP_OR_LIT = 8'h09;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [5:0] OP_COPY_FILE = 6'h14;
   localparam logic [9:0] OP_LOAD_PTR = 10'h3b8;
   localparam logic [7:0] OP_LOAD_PTR_2ND = 8'hf0;
   localparam logic [3:0] OP_MOVE_SRC = 4'hc;
   localparam logic [3:0] OP_MOVE_DST = 4'hf;
   // field positions
   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned ACCESS_BIT = 8;
   localparam int unsigned NEG_BIT = 7;
   // access bank split: low half in bank 0, high half in bank 15
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   // special addresses in data space
   localparam logic [11:0] ADDR_ACCUM = 12'hfe8;
   localparam logic [11:0] ADDR_PC_LOW = 12'hff9;
   localparam logic [11:0] ADDR_TOS_LOW = 12'hffd;
   localparam logic [11:0] ADDR_TOS_HIGH = 12'hffe;
   localparam logic [11:0] ADDR_TOS_UPPER = 12'hfff;
   // reset values
   localparam logic [7:0] ACCUM_RST = 8'h00;
   localparam logic [11:0] PTR_RST = 12'h000;
   // index of the last phase of one instruction cycle
   localparam logic [1:0] PHASE_LAST = 2'h3;
   typedef enum logic [1:0] {
      OMX_Q1,
      OMX_Q2,
      OMX_Q3,
      OMX_Q4
   } omx_phase_t;
   typedef enum {
      OMX_IDLE,
      OMX_PTR_LOW,
      OMX_MOVE_DST
   } omx_state_t;
endpackage

//--- verilog/omx_phase_gen.sv
// four-phase sequencer for the instruction cycle
`timescale 1ns/1ps
module omx_phase_gen (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   output omx_pkg::omx_phase_t o_phase,
   output logic o_cycle_start,
   output logic o_cycle_end
);
   import omx_pkg::*;
   logic [1:0] phase_r;

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_r + 2'h1;
      end
   end

   assign o_phase = omx_phase_t'(phase_r);
   assign o_cycle_start = (phase_r == 2'h0);
   assign o_cycle_end = (phase_r == PHASE_LAST);
endmodule

//--- test/omx_mem_model.sv
// data memory model on the far side of the execute block
`timescale 1ns/1ps
module omx_mem_model (
   input wire logic i_ref_clk,
   input wire logic i_rd,
   input wire logic [11:0] i_raddr,
   input wire logic i_wr,
   input wire logic [11:0] i_waddr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last_r = 8'h00;
   // bank nibble mixed in so a wrong bank reads a different value
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0] ^ {4'h0, i[11:8]};
      end
   end
   always @(posedge i_ref_clk) begin
      if (i_wr) begin
         mem[i_waddr] <= i_wdata;
      end
      last_r <= o_rdata;
   end
   // toggles outside the read strobe, so stale data never passes
   assign o_rdata = i_rd ? mem[i_raddr] : ~last_r;
endmodule

//--- test/omx_exec_monitor.sv
// port assertions for the execute block
`timescale 1ns/1ps
module omx_exec_monitor
   import omx_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_instr_word,
   input wire logic [3:0] i_bank_select,
   input wire logic [7:0] i_mem_rdata,
   input wire logic o_instr_taken,
   input wire logic o_mem_rd,
   input wire logic [11:0] o_mem_raddr,
   input wire logic o_mem_wr,
   input wire logic [11:0] o_mem_waddr,
   input wire logic [7:0] o_mem_wdata,
   input wire logic o_move_dest_refused,
   input wire logic [7:0] o_accum,
   input wire logic o_flag_neg,
   input wire logic o_flag_zero,
   input wire omx_phase_t o_phase
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   logic [15:0] w;
   logic ok, bad, nz_ok, mv1, wr_dst;
   logic [7:0] lit;
   logic [11:0] a12, ea;
   assign w = i_instr_word;
   assign ok = o_instr_taken;
   assign lit = w[7:0];
   assign a12 = w[11:0];
   assign ea = {w[8] ? i_bank_select : {4{w[7]}}, w[7:0]};
   assign bad = a12 == ADDR_PC_LOW || a12 >= ADDR_TOS_LOW;
   // accumulator kept in place, so no memory write is due for it
   assign wr_dst = !bad && a12 != ADDR_ACCUM;
   assign nz_ok = o_flag_neg == o_accum[7] &&
      o_flag_zero == (o_accum == 8'h00);
   assign mv1 = ok && w[15:12] == OP_MOVE_SRC;
   a_wr_in_q4: assert property (o_mem_wr |-> o_phase == OMX_Q4)
      else $error("write outside q4");
   a_rd_in_q2: assert property (o_mem_rd |-> o_phase == OMX_Q2)
      else $error("read outside q2");
   a_or_literal: assert property (ok && w[15:8] == OP_OR_LIT |->
      ##4 o_accum == ($past(o_accum, 4) | $past(lit, 4)) && nz_ok)
      else $error("or literal wrong");
   a_or_file_wr: assert property (ok && w[15:10] == OP_OR_FILE
      && w[9] |-> ##1 o_mem_rd ##2 o_mem_wr
      && o_mem_waddr == $past(o_mem_raddr, 2)
      && o_mem_wdata == ($past(i_mem_rdata, 2) | $past(o_accum, 3)))
      else $error("or file write wrong");
   a_bank_addr: assert property (ok && (w[15:10] == OP_OR_FILE ||
      w[15:10] == OP_COPY_FILE) |=> o_mem_rd && o_mem_raddr == $past(ea))
      else $error("bank address wrong");
   a_copy_acc: assert property (ok && w[15:10] == OP_COPY_FILE
      && !w[9] |-> ##4 o_accum == $past(i_mem_rdata, 3) && nz_ok)
      else $error("copy to accum wrong");
   a_move_flags: assert property (mv1 |=>
      ($stable(o_flag_neg) && $stable(o_flag_zero)) [*8])
      else $error("move touched flags");
   a_move_wr: assert property ($past(mv1, 4) && ok && wr_dst |->
      ##1 !o_mem_rd ##2 o_mem_wr && o_mem_waddr == $past(a12, 3))
      else $error("move write wrong");
   a_move_refuse: assert property ($past(mv1, 4) && ok && bad |->
      ##3 o_move_dest_refused && !o_mem_wr)
      else $error("move refusal wrong");
   c_move: cover property (mv1);
   c_refuse: cover property (o_move_dest_refused);
   c_write: cover property (o_mem_wr);
endmodule
bind omx_exec omx_exec_monitor u_mon (.*);

//--- test/or_move_load_instr_exec_tb_top.sv
// self-checking bench for the execute block
`timescale 1ns/1ps
module or_move_load_instr_exec_tb_top;
   import omx_pkg::*;
   typedef struct {
      logic [15:0] w;
      logic [3:0] b;
      logic [7:0] acc;
      logic [1:0] nz;
      logic wr;
      logic [11:0] wa;
      logic [7:0] wd;
   } omx_row_t;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_instr_valid = 1'b0;
   logic [15:0] i_instr_word = 16'h0000;
   logic [3:0] i_bank_select = 4'h0;
   logic [7:0] i_mem_rdata, o_mem_wdata, o_accum, lwd;
   logic o_instr_taken, o_unsupported, o_mem_rd, o_mem_wr;
   logic o_move_dest_refused, o_flag_neg, o_flag_zero;
   logic [11:0] o_mem_raddr, o_mem_waddr, o_ptr0, o_ptr1, o_ptr2, lwa;
   omx_phase_t o_phase;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int wcnt = 0;
   int rcnt = 0;
   int ucnt = 0;
   omx_row_t rows[8] = '{
      '{16'h099a, 4'h0, 8'h9a, 2'b10, 1'b0, 12'h000, 8'h00},
      '{16'h0935, 4'h0, 8'hbf, 2'b10, 1'b0, 12'h000, 8'h00},
      '{16'h5000, 4'h7, 8'h00, 2'b01, 1'b0, 12'h000, 8'h00},
      '{16'h0910, 4'h0, 8'h10, 2'b00, 1'b0, 12'h000, 8'h00},
      '{16'h1180, 4'h3, 8'h93, 2'b10, 1'b0, 12'h000, 8'h00},
      '{16'h12c4, 4'h0, 8'h93, 2'b10, 1'b1, 12'hfc4, 8'hdb},
      '{16'h53ff, 4'ha, 8'h93, 2'b10, 1'b1, 12'haff, 8'hf5},
      '{16'h5105, 4'h5, 8'h00, 2'b01, 1'b0, 12'h000, 8'h00}};
   omx_exec dut_u (.*);
   omx_mem_model mem_u (.i_ref_clk(i_ref_clk), .i_rd(o_mem_rd),
      .i_raddr(o_mem_raddr), .i_wr(o_mem_wr), .i_waddr(o_mem_waddr),
      .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
   always #5 i_ref_clk = ~i_ref_clk;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [11:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // word lands as the phase enters q1, held through the sampling edge
   task automatic send(input logic [15:0] w, input logic [3:0] b);
      // phase read at the falling edge, where it has settled
      do @(negedge i_ref_clk); while (o_phase !== OMX_Q4);
      @(posedge i_ref_clk);
      i_instr_word <= w;
      i_bank_select <= b;
      i_instr_valid <= 1'b1;
   endtask
   task automatic done();
      @(posedge i_ref_clk);
      i_instr_valid <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1;
   endtask
   // two-word move: source word, then destination word, bank select 0
   task automatic mv(input logic [11:0] s, d);
      send({4'hc, s}, 4'h0);
      send({4'hf, d}, 4'h0);
      done();
   endtask
   function automatic logic [11:0] ptr(int f);
      return f == 0 ? o_ptr0 : f == 1 ? o_ptr1 : o_ptr2;
   endfunction
   always @(posedge i_ref_clk) begin
      cyc++;
      if (o_mem_wr === 1'b1) begin
         wcnt++;
         lwa = o_mem_waddr;
         lwd = o_mem_wdata;
      end
      if (o_move_dest_refused === 1'b1) rcnt++;
      if (o_unsupported === 1'b1) ucnt++;
      // whole run needs well under a thousand cycles
      if (cyc == 3000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      int n;
      logic [11:0] bad[4] = '{12'hff9, 12'hffd, 12'hffe, 12'hfff};
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      foreach (rows[k]) begin
         n = wcnt;
         send(rows[k].w, rows[k].b);
         done();
         chk("accum", rows[k].acc, o_accum);
         chk("flags", rows[k].nz, {o_flag_neg, o_flag_zero});
         chk("writes", rows[k].wr, 12'(wcnt - n));
         if (rows[k].wr) begin
            chk("waddr", rows[k].wa, lwa);
            chk("wdata", rows[k].wd, lwd);
         end
         $display("row %0d done", k);
      end
      for (int f = 0; f < 3; f++) begin
         send({8'hee, 2'b00, 2'(f), 4'h3}, 4'h0);
         send({8'hf0, 6'h28, 2'(f)}, 4'h0);
         #1;
         chk("ptr high", 12'h003, ptr(f) >> 8);
         done();
         chk("ptr", {4'h3, 6'h28, 2'(f)}, ptr(f));
      end
      send(16'hee35, 4'h0);
      send(16'hf0aa, 4'h0);
      done();
      chk("ptr kept", 12'h3a2, o_ptr2);
      chk("unsupported", 12'h001, 12'(ucnt > 0));
      $display("pointer loads done");
      n = wcnt;
      mv(12'h123, 12'h456);
      chk("mv writes", 12'h001, 12'(wcnt - n));
      chk("mv addr", 12'h456, lwa);
      chk("mv data", 12'h022, 12'(lwd));
      mv(12'h123, ADDR_ACCUM);
      chk("mv to acc", 12'h022, 12'(o_accum));
      mv(ADDR_ACCUM, 12'h010);
      chk("mv from acc", 12'h022, 12'(lwd));
      chk("mv flags", 12'h001, {o_flag_neg, o_flag_zero});
      foreach (bad[k]) begin
         n = wcnt;
         mv(12'h001, bad[k]);
         chk("refused", 12'(k + 1), 12'(rcnt));
         chk("no write", 12'h000, 12'(wcnt - n));
      end
      $display("moves done");
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      @(posedge i_ref_clk);
      #1;
      chk("rst accum", 12'(ACCUM_RST), 12'(o_accum));
      chk("rst ptr", PTR_RST, o_ptr1);
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      send(16'h0955, 4'h0);
      send(16'h0980, 4'h0);
      done();
      chk("back to back", 12'h0d5, 12'(o_accum));
      $display("reset and back to back done");
      end_sim();
   end
endmodule
